/* File: rbx_pkg.sv */
// Package for the registered bus exchanger: widths, register map and carriers.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register master.
package rbx_pkg;

  localparam int NARROW_W   = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int AXI_AW     = 4;

  // Register byte offsets.
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_DATA   = 4'h8;

  // Field positions.
  localparam int CTRL_FIFO_EN = 0;
  localparam int ST_EMPTY     = 0;
  localparam int ST_FULL      = 1;
  localparam int ST_DROP      = 2;
  localparam int ST_NARROW_OE = 3;
  localparam int ST_FIRST_OE  = 4;
  localparam int ST_SECOND_OE = 5;

  // Values after reset.
  localparam logic CTRL_FIFO_EN_RST = 1'b0;
  localparam logic DRIVE_EN_N_RST   = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Active-low control pins of the exchanger, sampled together.
  typedef struct packed {
    logic first_half_capture_en_n;
    logic second_half_capture_en_n;
    logic source_sel_n;
    logic narrow_drive_en_n;
    logic first_half_drive_en_n;
    logic second_half_drive_en_n;
  } rbx_ctl_t;

  // Registered drive enables, active high toward the pads.
  typedef struct packed {
    logic narrow;
    logic first;
    logic second;
  } rbx_oe_t;

endpackage

/* File: rbx_exchanger.sv */
// Registered 12-bit to 24-bit bus exchanger with an AXI4-Lite register slave.
// Assumes all pins are synchronous to mclk; pads resolve value from the enables.
// How it works
// - Each wide half loads narrow data when enabled.
// - Successive half enables assemble one 24-bit word.
// - One narrow register captures the selected half.
// - Select high picks first, low second half.
// - Every control is sampled at the clock edge.
// - Ports drive only while registered enables high.
// - Drive state unknown until first clock edge.
// - Disabled halves hold value; narrow register reloads every edge.
// - Narrow output comes straight from a register.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns

module rbx_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("rbx_fifo: depth must be a power of two, at least 2");
  end

  // Full and empty come from the count, so they are exact.
  assign in_ready  = (cnt_q != (PW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  // Storage is written only on an accepted push.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule

module rbx_exchanger
  import rbx_pkg::*;
#(
  parameter int NW    = NARROW_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire rbx_ctl_t            ctl,
  input  wire logic [NW-1:0]       narrow_in,
  output logic [NW-1:0]            narrow_out,
  output logic                     narrow_oe,
  input  wire logic [NW-1:0]       first_wide_half_in,
  output logic [NW-1:0]            first_wide_half_out,
  output logic                     first_wide_half_oe,
  input  wire logic [NW-1:0]       second_wide_half_in,
  output logic [NW-1:0]            second_wide_half_out,
  output logic                     second_wide_half_oe,
  output logic                     fifo_in_ready,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  if (NW < 1 || 2 * NW > 32) begin : g_bad
    $error("rbx_exchanger: a wide word must fit one 32-bit register");
  end

  logic [NW-1:0]   first_q;
  logic [NW-1:0]   second_q;
  logic [NW-1:0]   first_d;
  logic [NW-1:0]   narrow_q;
  rbx_oe_t         oe_q;
  logic            fifo_en_q;
  logic            drop_q;
  logic            push_valid;
  logic            fifo_out_valid;
  logic            fifo_pop;
  logic [2*NW-1:0] fifo_out_data;
  logic            aw_q;
  logic            w_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]     wdata_q;
  logic [3:0]      wstrb_q;
  logic            wr_fire;
  logic            rd_fire;
  logic [31:0]     status;

  // A mapped register answers OKAY; everything else answers SLVERR.
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return a == OFS_CTRL || a == OFS_STATUS || a == OFS_DATA;
  endfunction

  // Wide halves load under their own capture enable, sampled at the edge.
  assign first_d = ctl.first_half_capture_en_n ? first_q : narrow_in;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      first_q  <= '0;
      second_q <= '0;
    end else begin
      first_q <= first_d;
      if (!ctl.second_half_capture_en_n) begin
        second_q <= narrow_in;
      end
    end
  end

  // The narrow register reloads every edge from the selected wide half.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      narrow_q <= '0;
    end else begin
      narrow_q <= ctl.source_sel_n ? first_wide_half_in
                                   : second_wide_half_in;
    end
  end

  // Drive enables pass through flip-flops; reset parks every port in high-Z,
  // which also gives a defined state where a bare part would be unknown.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      oe_q <= '{narrow: !DRIVE_EN_N_RST, first: !DRIVE_EN_N_RST,
                 second: !DRIVE_EN_N_RST};
    end else begin
      oe_q.narrow <= !ctl.narrow_drive_en_n;
      oe_q.first  <= !ctl.first_half_drive_en_n;
      oe_q.second <= !ctl.second_half_drive_en_n;
    end
  end

  // Data pins come straight from registers, valid for the whole period.
  assign narrow_out           = narrow_q;
  assign first_wide_half_out  = first_q;
  assign second_wide_half_out = second_q;
  assign narrow_oe            = oe_q.narrow;
  assign first_wide_half_oe   = oe_q.first;
  assign second_wide_half_oe  = oe_q.second;

  // While the FIFO is enabled, each second-half capture offers the assembled word to the FIFO.
  assign push_valid = fifo_en_q & !ctl.second_half_capture_en_n;

  rbx_fifo #(
    .WIDTH (2 * NW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({narrow_in, first_d}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // AXI write: address and data are taken in either order, then answered.
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign wr_fire       = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control and sticky drop flag; a drop in the clearing cycle survives.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fifo_en_q <= CTRL_FIFO_EN_RST;
      drop_q    <= 1'b0;
    end else begin
      if (wr_fire && awaddr_q == OFS_CTRL && wstrb_q[0]) begin
        fifo_en_q <= wdata_q[CTRL_FIFO_EN];
      end
      if (push_valid && !fifo_in_ready) begin
        drop_q <= 1'b1;
      end else if (wr_fire && awaddr_q == OFS_STATUS && wstrb_q[0] &&
                   wdata_q[ST_DROP]) begin
        drop_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status               = '0;
    status[ST_EMPTY]     = !fifo_out_valid;
    status[ST_FULL]      = !fifo_in_ready;
    status[ST_DROP]      = drop_q;
    status[ST_NARROW_OE] = oe_q.narrow;
    status[ST_FIRST_OE]  = oe_q.first;
    status[ST_SECOND_OE] = oe_q.second;
  end

  // AXI read: one cycle to answer; reading DATA pops one word if present.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign fifo_pop      = rd_fire && s_axi_araddr == OFS_DATA;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL:   s_axi_rdata <= 32'(fifo_en_q);
        OFS_STATUS: s_axi_rdata <= status;
        OFS_DATA:   s_axi_rdata <= fifo_out_valid ? 32'(fifo_out_data) : '0;
        default:    s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_first_load: assert property (
    !ctl.first_half_capture_en_n |=> first_wide_half_out == $past(narrow_in))
    else $error("first half did not load narrow data");
  a_second_load: assert property (
    !ctl.second_half_capture_en_n |=> second_wide_half_out == $past(narrow_in))
    else $error("second half did not load narrow data");
  a_word_pair: assert property (
    (!ctl.first_half_capture_en_n ##1 !ctl.second_half_capture_en_n) |=>
    second_wide_half_out == $past(narrow_in) &&
    first_wide_half_out == $past(narrow_in, 2))
    else $error("two words did not assemble into one wide word");
  a_sel_first: assert property (
    resetn && ctl.source_sel_n |=> narrow_out == $past(first_wide_half_in))
    else $error("select high did not pick first half");
  a_sel_second: assert property (
    !ctl.source_sel_n |=> narrow_out == $past(second_wide_half_in))
    else $error("select low did not pick second half");
  a_oe_delay: assert property (
    resetn |=> narrow_oe == !$past(ctl.narrow_drive_en_n))
    else $error("narrow enable not registered by one edge");
  a_halves_apart: assert property (
    ctl.first_half_drive_en_n && !ctl.second_half_drive_en_n |=>
    !first_wide_half_oe && second_wide_half_oe)
    else $error("wide half enables are not independent");
  a_hold_both: assert property (
    ctl.first_half_capture_en_n && ctl.second_half_capture_en_n |=>
    $stable(first_wide_half_out) && $stable(second_wide_half_out))
    else $error("wide halves changed while disabled");
  a_reset_hiz: assert property (
    @(posedge mclk) disable iff (1'b0) $rose(resetn) |->
    !narrow_oe && !first_wide_half_oe && !second_wide_half_oe)
    else $error("ports drive right after reset");
  // The edge that releases reset is still a reset edge, so the next three checks start one edge later.
  a_wide_oe_delay: assert property (
    resetn |=> first_wide_half_oe == !$past(ctl.first_half_drive_en_n) &&
    second_wide_half_oe == !$past(ctl.second_half_drive_en_n))
    else $error("wide enables not registered by one edge");
  a_first_hold: assert property (
    resetn && ctl.first_half_capture_en_n |=> $stable(first_wide_half_out))
    else $error("first half changed while its capture was off");
  a_second_hold: assert property (
    resetn && ctl.second_half_capture_en_n |=> $stable(second_wide_half_out))
    else $error("second half changed while its capture was off");
  a_full_drop: assert property (
    push_valid && !fifo_in_ready |=> drop_q)
    else $error("word offered to a full buffer was not flagged");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered on the next edge");

  c_word_pair: cover property (!ctl.first_half_capture_en_n ##1
                               !ctl.second_half_capture_en_n && fifo_en_q);
  c_fifo_full: cover property (!fifo_in_ready);
  c_data_read: cover property (fifo_pop);
  c_drop_clear: cover property (wr_fire && awaddr_q == OFS_STATUS && drop_q);
endmodule

/* File: rbx_far_bus.sv */
// Far-side model of one 12-bit pad shared by the exchanger and an outside bus.
// Assumes one clock and no pull resistor on the pad.
`timescale 1ns/1ns
module rbx_far_bus (
  input  wire logic        mclk,
  input  wire logic [11:0] dev_out,
  input  wire logic        dev_oe,
  input  wire logic [11:0] far_out,
  input  wire logic        far_oe,
  output logic      [11:0] pad
);
  logic [11:0] last_q = 12'h000;
  // A released pad flips every cycle, so stale data can never pass for a match.
  always_comb begin
    if (dev_oe) begin
      pad = dev_out;
    end else if (far_oe) begin
      pad = far_out;
    end else begin
      pad = ~last_q;
    end
  end
  // Last level seen on the pad.
  always_ff @(posedge mclk) last_q <= pad;
endmodule

/* File: rbx_exchanger_test.sv */
// Testbench of the registered bus exchanger: pin scenarios and register access.
// Assumes the far-side pad model and an AXI4-Lite master written here.
`timescale 1ns/1ns
module rbx_exchanger_test;
  import rbx_pkg::*;
  logic        mclk = 0, resetn = 0, far_oe = 0;
  rbx_ctl_t    ctl;
  logic [11:0] narrow_in, narrow_out, first_wide_half_in, first_wide_half_out;
  logic [11:0] second_wide_half_in, second_wide_half_out, nar_far = 12'h000;
  logic        narrow_oe, first_wide_half_oe, second_wide_half_oe, fifo_in_ready;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready = 0;
  int          error_cnt = 0, compares = 0;

  rbx_exchanger rbx_exchanger_inst (.mclk, .resetn, .ctl, .narrow_in, .narrow_out, .narrow_oe,
    .first_wide_half_in, .first_wide_half_out, .first_wide_half_oe, .second_wide_half_in,
    .second_wide_half_out, .second_wide_half_oe, .fifo_in_ready, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // The wide side is only ever driven by the block, so its far drivers stay off.
  rbx_far_bus nar_bus_inst (.mclk, .dev_out(narrow_out), .dev_oe(narrow_oe), .far_out(nar_far),
    .far_oe, .pad(narrow_in));
  rbx_far_bus fw_bus_inst (.mclk, .dev_out(first_wide_half_out), .dev_oe(first_wide_half_oe),
    .far_out(12'h000), .far_oe(1'b0), .pad(first_wide_half_in));
  rbx_far_bus sw_bus_inst (.mclk, .dev_out(second_wide_half_out), .dev_oe(second_wide_half_oe),
    .far_out(12'h000), .far_oe(1'b0), .pad(second_wide_half_in));

  // Free-running 125 MHz clock.
  always #4 mclk = ~mclk;

  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic hang(input string m);
    error_cnt++;
    $display("CHECK FAILED t=%0t %s timed out", $time, m);
    close_out();
  endtask

  // Address and data are offered together; each is released once it is taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    rs = s_axi_bresp;
    if (n == 50) hang("write");
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    v = s_axi_rdata;
    rs = s_axi_rresp;
    if (n == 50) hang("read");
  endtask

  // Two narrow words, first then second half, on back-to-back edges.
  task automatic pair(input logic [11:0] lo, input logic [11:0] hi);
    @(posedge mclk);
    ctl.first_half_capture_en_n <= 0; nar_far <= lo; far_oe <= 1;
    @(posedge mclk);
    ctl.first_half_capture_en_n <= 1; ctl.second_half_capture_en_n <= 0; nar_far <= hi;
    @(posedge mclk);
    ctl.second_half_capture_en_n <= 1; nar_far <= 12'hFFF;
  endtask

  task automatic t_capture;
    #1 chk({narrow_oe, first_wide_half_oe, second_wide_half_oe}, 0, "oe after reset");
    @(posedge mclk);
    ctl.first_half_drive_en_n <= 0; ctl.second_half_drive_en_n <= 0;
    pair(12'hA5C, 12'h3F1);
    #1 chk({second_wide_half_out, first_wide_half_out}, 24'h3F1A5C, "assembled word");
    chk(first_wide_half_out, 12'hA5C, "first half load");
    chk({first_wide_half_in, second_wide_half_in}, 24'hA5C3F1, "wide pads driven");
    repeat (3) @(posedge mclk);
    #1 chk({second_wide_half_out, first_wide_half_out}, 24'h3F1A5C, "halves held");
    @(posedge mclk);
    ctl.second_half_drive_en_n <= 1; far_oe <= 0;
    @(posedge mclk);
    #1 chk({first_wide_half_oe, second_wide_half_oe}, 2'b10, "separate half enables");
    @(posedge mclk);
    ctl.first_half_drive_en_n <= 1; ctl.second_half_drive_en_n <= 0;
    @(posedge mclk);
    #1 chk({first_wide_half_oe, second_wide_half_oe}, 2'b01, "second half alone");
  endtask

  // Both wide pads must be driven before the narrow register can pick them up.
  task automatic t_select;
    @(posedge mclk);
    ctl.source_sel_n <= 1; ctl.first_half_drive_en_n <= 0;
    repeat (2) @(posedge mclk);
    #1 chk(narrow_out, 12'hA5C, "select high first half");
    @(posedge mclk);
    ctl.source_sel_n <= 0; ctl.narrow_drive_en_n <= 0;
    #1 chk(narrow_oe, 0, "enable waits for edge");
    @(posedge mclk);
    #1 chk(narrow_out, 12'h3F1, "select low second half");
    chk(narrow_in, 12'h3F1, "narrow pad driven");
    #6 chk(narrow_out, 12'h3F1, "narrow value late in cycle");
    @(posedge mclk);
    ctl.narrow_drive_en_n <= 1; ctl.second_half_drive_en_n <= 1;
  endtask

  // Seventeen words into a sixteen-word buffer: the last is dropped and flagged.
  task automatic t_fifo;
    wr(OFS_CTRL, 32'h1, r);
    chk(r, RESP_OKAY, "ctrl write");
    for (int i = 0; i < 17; i++) pair(12'(i), 12'h800 | 12'(i));
    #1 chk(fifo_in_ready, 0, "buffer full");
    rd(OFS_STATUS, d, r);
    chk(d, (1 << ST_FULL) | (1 << ST_DROP) | (1 << ST_FIRST_OE), "status full");
    for (int i = 0; i < 16; i++) begin
      rd(OFS_DATA, d, r);
      chk(d, {8'h00, 12'h800 | 12'(i), 12'(i)}, "popped word");
    end
    wr(OFS_STATUS, 1 << ST_DROP, r);
    rd(OFS_STATUS, d, r);
    chk(d, (1 << ST_EMPTY) | (1 << ST_FIRST_OE), "status empty");
    rd(OFS_DATA, d, r);
    chk(r, RESP_OKAY, "empty pop response");
    chk(d, 32'h0, "empty pop data");
    rd(4'hC, d, r);
    chk(r, RESP_SLVERR, "unmapped read");
    wr(4'hC, 32'h1, r);
    chk(r, RESP_SLVERR, "unmapped write");
    rd(OFS_CTRL, d, r);
    chk(d, 32'h1, "ctrl readback");
  endtask

  // Enables are held inactive through power-up, as the outside party should.
  initial begin
    ctl = '1;
    repeat (2) @(posedge mclk);
    resetn <= 1;
    rd(OFS_CTRL, d, r);
    chk(d, 32'(CTRL_FIFO_EN_RST), "ctrl after reset");
    t_capture();
    t_select();
    t_fifo();
    close_out();
  end
endmodule
